// *** rtl/wpps_pkg.sv ***
// Purpose: constants shared by the wake packet and power state logic
// Assumes: one clock domain, byte-wide receive stream from the MAC
// Notes: power state encoding follows the two-bit power-state field
//
// Function
// - A wake packet is at least six 0xff bytes followed at once by sixteen copies of the station address.
// - A frame counts as a wake packet only if its address passed the filter and its check sequence is good.
// - The pattern may appear several times in one frame and any occurrence is enough.
// - The wake enable bit is loaded from the EEPROM after reset and may later be written by the driver.
// - With wake enable set, a wake packet drives the active-low event pin and sets the event status flag.
// - In D1, D2 and D3hot only configuration cycles are answered and the function context is kept.
// - In D1, D2 and D3hot nothing is initiated on the network apart from a wake-up event.
// - After D3cold the host asserts bus reset and the device comes up in D0 with no earlier context.
// - Going from D3hot to D0 resets the function internally without the reset pin.
// - In D3hot configuration cycles are still answered while power and clock are present.
// - In D0 any bus transaction is accepted and any transaction or interrupt may be started; the code does so only once the internal reset has run out.

package wpps_pkg;

  typedef enum logic [1:0] {
    WPPS_D0 = 2'h0,
    WPPS_D1 = 2'h1,
    WPPS_D2 = 2'h2,
    WPPS_D3HOT = 2'h3
  } wpps_pstate_e;

  // pattern shape
  localparam int unsigned SYNC_BYTES = 6;
  localparam int unsigned ADDR_COPIES = 16;
  localparam int unsigned ADDR_BYTES = 6;
  localparam logic [7:0] SYNC_VALUE = 8'hff;

  // counter widths and limits
  localparam logic [2:0] SYNC_LAST = 3'h6;
  localparam logic [2:0] ADDR_IDX_LAST = 3'h5;
  localparam logic [3:0] COPY_LAST = 4'hf;

  // configuration word 18 and status word 20 field positions
  localparam int unsigned CFG18_WAKE_ENABLE_BIT = 18;
  localparam int unsigned STATUS20_PME_BIT = 15;

  // reset values
  localparam logic WAKE_ENABLE_RESET = 1'b0;
  localparam logic PME_STATUS_RESET = 1'b0;

  // internal function reset on D3hot to D0
  localparam int unsigned CLOCK_HZ = 10_000_000;
  localparam int unsigned FUNC_RESET_NS = 400;
  localparam int unsigned FUNC_RESET_CYCLES_RAW =
      (FUNC_RESET_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned FUNC_RESET_CYCLES =
      (FUNC_RESET_CYCLES_RAW < 1) ? 1 : FUNC_RESET_CYCLES_RAW;
  localparam logic [3:0] FUNC_RESET_LOAD = 4'(FUNC_RESET_CYCLES);

endpackage : wpps_pkg

// *** rtl/wpps_pattern_match.sv ***
// Purpose: finds the sync-plus-address pattern in one receive frame
// Assumes: bytes arrive one per valid cycle, first address byte in [7:0]
// Notes: found stays set until the next start of frame or soft_rst

`timescale 1ns/10ps
`default_nettype none

module wpps_pattern_match (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_rst,
  // byte stream
  input wire logic sof,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic [47:0] station_addr,
  // result
  output logic found
);

  typedef enum logic [0:0] {PM_SYNC, PM_ADDR} wpps_pm_state_e;

  wpps_pm_state_e state_r;
  logic [2:0] ff_cnt_r;
  logic [2:0] idx_r;
  logic [3:0] copy_r;
  logic found_r;
  logic [7:0] expect_byte;
  logic is_sync;

  assign expect_byte = station_addr[{idx_r, 3'h0} +: 8];
  assign is_sync = (byte_data == wpps_pkg::SYNC_VALUE);
  assign found = found_r;

  //////////////////////////////////////////////////////////////////////////
  // sequence tracker

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= PM_SYNC;
      ff_cnt_r <= 3'h0;
      idx_r <= 3'h0;
      copy_r <= 4'h0;
    end else if (soft_rst || sof) begin
      state_r <= PM_SYNC;
      ff_cnt_r <= 3'h0;
      idx_r <= 3'h0;
      copy_r <= 4'h0;
    end else if (byte_valid) begin
      case (state_r)
        PM_SYNC: begin
          if (ff_cnt_r == wpps_pkg::SYNC_LAST && byte_data == expect_byte) begin
            state_r <= PM_ADDR;
            idx_r <= idx_r + 3'h1;
          end else if (is_sync) begin
            if (ff_cnt_r != wpps_pkg::SYNC_LAST) begin
              ff_cnt_r <= ff_cnt_r + 3'h1;
            end
          end else begin
            ff_cnt_r <= 3'h0;
          end
        end
        PM_ADDR: begin
          if (byte_data == expect_byte) begin
            if (idx_r == wpps_pkg::ADDR_IDX_LAST) begin
              idx_r <= 3'h0;
              copy_r <= copy_r + 4'h1;
              if (copy_r == wpps_pkg::COPY_LAST) begin
                state_r <= PM_SYNC;
                ff_cnt_r <= 3'h0;
                copy_r <= 4'h0;
              end
            end else begin
              idx_r <= idx_r + 3'h1;
            end
          end else begin
            state_r <= PM_SYNC;
            idx_r <= 3'h0;
            copy_r <= 4'h0;
            ff_cnt_r <= is_sync ? 3'h1 : 3'h0;
          end
        end
        default: begin
          state_r <= PM_SYNC;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sticky match flag for the frame

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      found_r <= 1'b0;
    end else if (soft_rst || sof) begin
      found_r <= 1'b0;
    end else if (byte_valid && state_r == PM_ADDR && byte_data == expect_byte &&
                 idx_r == wpps_pkg::ADDR_IDX_LAST && copy_r == wpps_pkg::COPY_LAST) begin
      found_r <= 1'b1;
    end
  end

endmodule : wpps_pattern_match

`default_nettype wire

// *** rtl/wpps_top.sv ***
// Purpose: wake packet detection, event pin and power state behaviour
// Assumes: receive MAC, filter, EEPROM loader and PCI target live outside
// Notes: event pin is open drain, driven low only

`timescale 1ns/10ps
`default_nettype none

module wpps_top (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // receive frame stream from the MAC
  input wire logic RX_SOF,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_BYTE,
  input wire logic RX_EOF,
  input wire logic RX_ADDR_PASS,
  input wire logic RX_FCS_OK,
  input wire logic [47:0] STATION_ADDR,
  // wake enable sources and event status clear
  input wire logic EE_LOAD_VALID,
  input wire logic [31:0] EE_CONFIG_WORD_18,
  input wire logic CONFIG_WORD_18_WR,
  input wire logic [31:0] CONFIG_WORD_18_WDATA,
  input wire logic PME_STATUS_CLR,
  // power state control from configuration space
  input wire logic PSTATE_WR,
  input wire logic [1:0] PSTATE_WDATA,
  // bus access qualification
  input wire logic BUS_REQ,
  input wire logic BUS_IS_CFG,
  output logic BUS_ACCEPT,
  // initiation requests from the function
  input wire logic MASTER_REQ_IN,
  input wire logic IRQ_IN,
  input wire logic TX_REQ_IN,
  output logic MASTER_REQ,
  output logic IRQ,
  output logic TX_REQ,
  // state outputs
  output logic [1:0] PSTATE,
  output logic FUNC_RESET_N,
  output logic WAKE_PACKET_ENABLE,
  output logic [31:0] STATUS_WORD_20,
  // event pin, open drain
  input wire logic PME_N_I,
  output logic PME_N_O,
  output logic PME_N_OE
);

  wpps_pkg::wpps_pstate_e pstate_r;
  wpps_pkg::wpps_pstate_e pstate_nxt;
  logic [3:0] frst_cnt_r;
  logic frst_active;
  logic wake_enable_r;
  logic pme_status_r;
  logic found;
  logic frame_wake;
  logic in_d0;
  logic pin_seen_r;
  logic pin_meta_r;
  logic pin_sync_r;
  logic frame_open_r;
  logic frame_good;
  logic wake_event;
  logic leave_d3hot;
  logic func_live;

  //////////////////////////////////////////////////////////////////////////
  // state decode

  assign in_d0 = (pstate_r == wpps_pkg::WPPS_D0);
  assign frst_active = (frst_cnt_r != 4'h0);
  assign pstate_nxt = wpps_pkg::wpps_pstate_e'(PSTATE_WDATA);
  assign leave_d3hot = PSTATE_WR && (pstate_r == wpps_pkg::WPPS_D3HOT) &&
                       (pstate_nxt == wpps_pkg::WPPS_D0);
  // full function only in D0 once the internal reset has run out
  assign func_live = in_d0 && !frst_active;

  //////////////////////////////////////////////////////////////////////////
  // power state register

  // bus reset always lands in D0 with context gone
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      pstate_r <= wpps_pkg::WPPS_D0;
    end else if (PSTATE_WR) begin
      pstate_r <= pstate_nxt;
    end
  end

  // internal function reset on D3hot to D0
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      frst_cnt_r <= 4'h0;
    end else if (leave_d3hot) begin
      frst_cnt_r <= wpps_pkg::FUNC_RESET_LOAD;
    end else if (frst_active) begin
      frst_cnt_r <= frst_cnt_r - 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // wake enable bit of configuration word 18

  // driver writes reach it only in D0; EEPROM load has priority
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      wake_enable_r <= wpps_pkg::WAKE_ENABLE_RESET;
    end else if (frst_active) begin
      wake_enable_r <= wpps_pkg::WAKE_ENABLE_RESET;
    end else if (EE_LOAD_VALID) begin
      wake_enable_r <= EE_CONFIG_WORD_18[wpps_pkg::CFG18_WAKE_ENABLE_BIT];
    end else if (CONFIG_WORD_18_WR && in_d0) begin
      wake_enable_r <= CONFIG_WORD_18_WDATA[wpps_pkg::CFG18_WAKE_ENABLE_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pattern search over the receive stream, live in every state

  wpps_pattern_match u_match (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .soft_rst(frst_active),
    .sof(RX_SOF),
    .byte_valid(RX_VALID),
    .byte_data(RX_BYTE),
    .station_addr(STATION_ADDR),
    .found(found)
  );

  //////////////////////////////////////////////////////////////////////////
  // frame bracketing

  // open from start marker to end marker; a stray end marker must not
  // reuse the match flag left over from the previous frame;
  // a start marker wins over an end marker in the same cycle
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      frame_open_r <= 1'b0;
    end else if (frst_active) begin
      frame_open_r <= 1'b0;
    end else if (RX_SOF) begin
      frame_open_r <= 1'b1;
    end else if (RX_EOF) begin
      frame_open_r <= 1'b0;
    end
  end

  // match only counts once the frame closes good and filtered
  assign frame_good = RX_EOF && frame_open_r && RX_ADDR_PASS && RX_FCS_OK;
  assign frame_wake = frame_good && found;
  assign wake_event = frame_wake && wake_enable_r;

  //////////////////////////////////////////////////////////////////////////
  // event status flag and pin

  // set wins over a clear in the same cycle; flag survives the
  // internal reset so the wake cause is still visible afterwards
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      pme_status_r <= wpps_pkg::PME_STATUS_RESET;
    end else if (wake_event) begin
      pme_status_r <= 1'b1;
    end else if (PME_STATUS_CLR) begin
      pme_status_r <= 1'b0;
    end
  end

  // the shared line comes from off chip: two flops before any use,
  // resting at the released level
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      pin_meta_r <= 1'b1;
      pin_sync_r <= 1'b1;
    end else begin
      pin_meta_r <= PME_N_I;
      pin_sync_r <= pin_meta_r;
    end
  end

  // pin readback, kept for diagnostics of a shared wired line
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      pin_seen_r <= 1'b0;
    end else begin
      pin_seen_r <= ~pin_sync_r & ~pme_status_r;
    end
  end

  assign PME_N_O = 1'b0;
  assign PME_N_OE = pme_status_r;

  //////////////////////////////////////////////////////////////////////////
  // bus access and initiation gating

  // configuration cycles always pass, other space only in D0
  assign BUS_ACCEPT = BUS_REQ && (BUS_IS_CFG || func_live);

  assign MASTER_REQ = MASTER_REQ_IN && func_live;
  assign IRQ = IRQ_IN && func_live;
  assign TX_REQ = TX_REQ_IN && func_live;

  //////////////////////////////////////////////////////////////////////////
  // state outputs

  assign PSTATE = pstate_r;
  assign FUNC_RESET_N = ~frst_active;
  assign WAKE_PACKET_ENABLE = wake_enable_r;

  always_comb begin
    STATUS_WORD_20 = 32'h0;
    STATUS_WORD_20[wpps_pkg::STATUS20_PME_BIT] = pme_status_r;
  end

endmodule : wpps_top

`default_nettype wire

// *** test/wpps_host_model.sv ***
// Purpose: host side of the event pin
// Assumes: pin has a pull-up on the board
// Notes: counts wake-up events seen by the host
`timescale 1ns/10ps
`default_nettype none
module wpps_host_model (
  // device pin halves
  input wire logic clock,
  input wire logic pme_n_o,
  input wire logic pme_n_oe,
  // resolved pin and count
  output logic pme_n,
  output var int wake_cnt
);
  logic last_r = 1'b1;
  initial wake_cnt = 0;
  // released pin floats to the pull-up level
  assign pme_n = pme_n_oe ? pme_n_o : 1'b1;
  // bus clock kept below the 16 MHz guidance, frames not judged on it
  always @(posedge clock) begin
    last_r <= pme_n;
    if (last_r && !pme_n) wake_cnt <= wake_cnt + 1;
  end
endmodule : wpps_host_model
`default_nettype wire

// *** test/wpps_asserts.sv ***
// Purpose: port checks of the wake and power logic
// Assumes: single clock, async active-low reset
// Notes: bind follows the module
`timescale 1ns/10ps
`default_nettype none
module wpps_asserts (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // inputs
  input wire logic RX_EOF,
  input wire logic RX_ADDR_PASS,
  input wire logic RX_FCS_OK,
  input wire logic EE_LOAD_VALID,
  input wire logic [31:0] EE_CONFIG_WORD_18,
  input wire logic PME_STATUS_CLR,
  input wire logic PSTATE_WR,
  input wire logic [1:0] PSTATE_WDATA,
  input wire logic BUS_REQ,
  input wire logic BUS_IS_CFG,
  input wire logic MASTER_REQ_IN,
  input wire logic IRQ_IN,
  input wire logic TX_REQ_IN,
  // outputs
  input wire logic BUS_ACCEPT,
  input wire logic MASTER_REQ,
  input wire logic IRQ,
  input wire logic TX_REQ,
  input wire logic [1:0] PSTATE,
  input wire logic FUNC_RESET_N,
  input wire logic WAKE_PACKET_ENABLE,
  input wire logic [31:0] STATUS_WORD_20,
  input wire logic PME_N_O,
  input wire logic PME_N_OE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  logic on_d0, leave3, ee_bit, st;
  assign on_d0 = (PSTATE == wpps_pkg::WPPS_D0) && FUNC_RESET_N;
  assign leave3 = PSTATE_WR && PSTATE_WDATA == wpps_pkg::WPPS_D0 && PSTATE == wpps_pkg::WPPS_D3HOT;
  assign ee_bit = EE_CONFIG_WORD_18[wpps_pkg::CFG18_WAKE_ENABLE_BIT];
  assign st = STATUS_WORD_20[wpps_pkg::STATUS20_PME_BIT];
  bus_gate_a: assert property (BUS_ACCEPT == (BUS_REQ && (BUS_IS_CFG || on_d0)))
    else $error("bus accept gating wrong");
  master_gate_a: assert property (MASTER_REQ == (MASTER_REQ_IN && on_d0))
    else $error("master request gating wrong");
  irq_gate_a: assert property (IRQ == (IRQ_IN && on_d0))
    else $error("interrupt gating wrong");
  tx_gate_a: assert property (TX_REQ == (TX_REQ_IN && on_d0))
    else $error("transmit request gating wrong");
  pme_hold_a: assert property (PME_N_OE && !PME_STATUS_CLR |=> PME_N_OE)
    else $error("event pin released early");
  pme_follow_a: assert property ($rose(st) |-> PME_N_OE && !PME_N_O)
    else $error("event pin not driven");
  wake_cause_a: assert property ($rose(st) |-> $past(RX_EOF && RX_ADDR_PASS && RX_FCS_OK))
    else $error("status set without good frame");
  func_reset_a: assert property (leave3 |=> !FUNC_RESET_N [*4] ##1 FUNC_RESET_N)
    else $error("internal reset length wrong");
  ee_load_a: assert property (EE_LOAD_VALID |=> WAKE_PACKET_ENABLE == $past(ee_bit))
    else $error("wake enable not loaded");
  wake_c: cover property ($rose(st));
  leave_c: cover property (leave3);
  cfg_c: cover property (BUS_ACCEPT && PSTATE == wpps_pkg::WPPS_D3HOT);
endmodule : wpps_asserts
bind wpps_top wpps_asserts u_chk (.CLOCK(CLOCK), .RESET_N(RESET_N), .RX_EOF(RX_EOF),
  .RX_ADDR_PASS(RX_ADDR_PASS), .RX_FCS_OK(RX_FCS_OK), .EE_LOAD_VALID(EE_LOAD_VALID),
  .EE_CONFIG_WORD_18(EE_CONFIG_WORD_18), .PME_STATUS_CLR(PME_STATUS_CLR),
  .PSTATE_WR(PSTATE_WR), .PSTATE_WDATA(PSTATE_WDATA), .BUS_REQ(BUS_REQ),
  .BUS_IS_CFG(BUS_IS_CFG), .MASTER_REQ_IN(MASTER_REQ_IN), .IRQ_IN(IRQ_IN),
  .TX_REQ_IN(TX_REQ_IN), .BUS_ACCEPT(BUS_ACCEPT), .MASTER_REQ(MASTER_REQ), .IRQ(IRQ),
  .TX_REQ(TX_REQ), .PSTATE(PSTATE),
  .FUNC_RESET_N(FUNC_RESET_N), .WAKE_PACKET_ENABLE(WAKE_PACKET_ENABLE),
  .STATUS_WORD_20(STATUS_WORD_20), .PME_N_O(PME_N_O), .PME_N_OE(PME_N_OE));
`default_nettype wire

// *** test/wpps_top_tb.sv ***
// Purpose: self-checking bench of wpps_top
// Assumes: inputs change at the falling edge
// Notes: seed fixed for repeatable runs
`timescale 1ns/10ps
`default_nettype none
module wpps_top_tb;
  logic clock = 1'b0, reset_n = 1'b0;
  logic sof, valid, eof, pass, ok, ee_ld, cw_wr, clr, ps_wr, req, cfg, m_in, i_in, t_in;
  logic acc, m_o, i_o, t_o, fr_n, wen, oe, po, pin, wen_m;
  logic [7:0] rxb;
  logic [47:0] addr;
  logic [31:0] ee_w, cw_d, st;
  logic [1:0] ps_d, ps;
  int mismatches = 0, n_checks = 0, cyc = 0, wakes, exp_w = 0, n;
  always #50 clock = ~clock;
  wpps_top dut (.CLOCK(clock), .RESET_N(reset_n), .RX_SOF(sof), .RX_VALID(valid),
    .RX_BYTE(rxb), .RX_EOF(eof), .RX_ADDR_PASS(pass), .RX_FCS_OK(ok), .STATION_ADDR(addr),
    .EE_LOAD_VALID(ee_ld), .EE_CONFIG_WORD_18(ee_w), .CONFIG_WORD_18_WR(cw_wr),
    .CONFIG_WORD_18_WDATA(cw_d), .PME_STATUS_CLR(clr), .PSTATE_WR(ps_wr),
    .PSTATE_WDATA(ps_d), .BUS_REQ(req), .BUS_IS_CFG(cfg), .BUS_ACCEPT(acc),
    .MASTER_REQ_IN(m_in), .IRQ_IN(i_in), .TX_REQ_IN(t_in), .MASTER_REQ(m_o), .IRQ(i_o),
    .TX_REQ(t_o), .PSTATE(ps), .FUNC_RESET_N(fr_n), .WAKE_PACKET_ENABLE(wen),
    .STATUS_WORD_20(st), .PME_N_I(pin), .PME_N_O(po), .PME_N_OE(oe));
  wpps_host_model host (.clock(clock), .pme_n_o(po), .pme_n_oe(oe), .pme_n(pin),
    .wake_cnt(wakes));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      end_of_test();
    end
  end
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s exp %0h got %0h", what, exp, got);
    end
  endtask : check
  task automatic tick(int k = 1);
    repeat (k) @(negedge clock);
  endtask : tick
  task automatic put(logic [7:0] b);
    valid = 1'b1;
    rxb = b;
    tick();
  endtask : put
  task automatic frame(int nff, int ncp, logic ap, logic fk, logic rep);
    logic w;
    w = nff >= 6 && ncp >= 16 && ap && fk && wen_m;
    sof = 1'b1;
    tick();
    sof = 1'b0;
    repeat ($urandom_range(3)) put(8'($urandom) & 8'h7f);
    if (rep) begin
      repeat (6) put(8'hff);
      put(addr[7:0]);
      put(~addr[15:8] & 8'h7f);
    end
    repeat (nff) put(8'hff);
    repeat (ncp) for (int i = 0; i < 6; i++) put(addr[8*i +: 8]);
    valid = 1'b0;
    tick();
    {eof, pass, ok} = {1'b1, ap, fk};
    tick();
    eof = 1'b0;
    tick(4);
    check("status", {16'h0, w, 15'h0}, st);
    check("pin", !w, pin);
    exp_w += w;
    clr = 1'b1;
    tick();
    clr = 1'b0;
    tick(2);
    check("cleared pin", 1'b1, pin);
    eof = 1'b1;
    tick();
    eof = 1'b0;
    tick(2);
    check("stray eof", 32'h0, st);
  endtask : frame
  task automatic set_en(logic v);
    cw_d = {13'h0, v, 18'h0};
    cw_wr = 1'b1;
    tick();
    cw_wr = 1'b0;
    tick();
    if (ps_d == 2'h0) wen_m = v;
    check("enable", wen_m, wen);
  endtask : set_en
  task automatic pstate(logic [1:0] s);
    ps_d = s;
    ps_wr = 1'b1;
    tick();
    ps_wr = 1'b0;
    n = 0;
    repeat (6) begin
      n += (fr_n === 1'b0);
      tick();
    end
    check("state", s, ps);
  endtask : pstate
  task automatic bus(logic on);
    repeat (4) begin
      {cfg, m_in, i_in, t_in} = 4'($urandom);
      req = 1'b1;
      #10;
      check("accept", cfg | on, acc);
      check("initiate", {m_in, i_in, t_in} & {3{on}}, {m_o, i_o, t_o});
      tick();
    end
    req = 1'b0;
  endtask : bus
  initial begin
    {sof, valid, eof, pass, ok, ee_ld, cw_wr, clr, ps_wr, req, cfg, m_in, i_in, t_in} = '0;
    {rxb, ee_w, cw_d, ps_d, wen_m} = '0;
    void'($urandom(29));
    addr = {16'($urandom), 32'($urandom)} & 48'hffff_ffff_ff7f;
    tick(6);
    reset_n = 1'b1;
    tick();
    check("reset state", 32'h1, {27'h0, wen, oe, ps, fr_n});
    check("reset status", 32'h0, st);
    ee_w = 32'h0004_0000;
    ee_ld = 1'b1;
    tick();
    ee_ld = 1'b0;
    check("eeprom enable", 32'h1, {31'h0, wen});
    wen_m = 1'b1;
    set_en(1'b1);
    frame(6, 16, 1, 1, 0);
    frame(5, 16, 1, 1, 0);
    frame(7, 15, 1, 1, 0);
    frame(9, 16, 0, 1, 0);
    frame(6, 16, 1, 0, 0);
    frame(6, 17, 1, 1, 1);
    repeat (12) frame(4 + $urandom_range(4), 14 + $urandom_range(3), 1'($urandom),
      1'($urandom), 1'($urandom));
    set_en(1'b0);
    frame(6, 16, 1, 1, 0);
    set_en(1'b1);
    bus(1'b1);
    for (int s = 1; s < 4; s++) begin
      pstate(2'(s));
      bus(1'b0);
    end
    set_en(1'b0);
    frame(6, 16, 1, 1, 1);
    pstate(2'h0);
    check("reset cycles", wpps_pkg::FUNC_RESET_CYCLES, n);
    check("enable lost", 1'b0, wen);
    wen_m = 1'b0;
    set_en(1'b1);
    frame(6, 16, 1, 1, 0);
    pstate(2'h2);
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    tick();
    check("after reset", 2'h0, ps);
    check("enable after reset", 32'h0, {31'h0, wen});
    check("wake count", exp_w, wakes);
    end_of_test();
  end
endmodule : wpps_top_tb
`default_nettype wire
